/* File: slc_pkg.sv */
// Purpose: shared constants and types for the sleep controller
// Assumes: 40 MHz clk_i, registers reached over Avalon-MM with 32-bit data
// Notes: byte offsets; each register takes one aligned word
package slc_pkg;

  // register map (byte addresses)
  localparam logic [3:0] SLC_CTRL_OFS = 4'h0;
  localparam logic [3:0] SLC_STAT_OFS = 4'h4;

  // sleep_control fields
  localparam int SLC_EN_BIT = 0;
  localparam int SLC_MODE_LSB = 1;
  localparam int SLC_CTRL_W = 3;
  localparam logic [SLC_CTRL_W-1:0] SLC_CTRL_RST = 3'h0;

  // sleep_status fields
  localparam int SLC_STAT_MODE_LSB = 0;
  localparam int SLC_STAT_ASLEEP_BIT = 2;
  localparam int SLC_STAT_WAKING_BIT = 3;

  // brown-out fuse value that makes wake-up wait for detector ready
  localparam logic [1:0] SLC_BROWNOUT_WAIT_FUSE = 2'h3;

  // peripheral clock cycles counted in the wake-up settle phase before resume
  localparam int SLC_WAKE_CYCLES = 6;

  typedef enum logic [1:0]
  {
    SLC_MODE_IDLE = 2'h0,
    SLC_MODE_STANDBY = 2'h1,
    SLC_MODE_POWER_DOWN = 2'h2,
    SLC_MODE_RSVD = 2'h3
  } slc_mode_t;

  // gray order along active -> sleep -> osc wait -> settle -> active
  typedef enum logic [1:0]
  {
    SLC_ST_ACTIVE = 2'b00,
    SLC_ST_SLEEP = 2'b01,
    SLC_ST_OSC = 2'b11,
    SLC_ST_SETTLE = 2'b10
  } slc_state_t;

  typedef struct packed
  {
    logic cpu;
    logic per;
    logic rtc;
    logic touch;
    logic main_osc;
    logic rtc_osc;
    logic ulp_osc;
    logic wdt;
    logic periodic_interval_timer;
  } slc_gates_t;

  localparam slc_gates_t SLC_GATES_RST = 9'h1ff;

endpackage : slc_pkg

/* File: slc_wake_filter.sv */
// Purpose: selects which interrupt sources may wake the device in each sleep mode
// Assumes: every source input is already gated by its own enable and the global enable
// Notes: purely combinational; the caller registers the decision
`timescale 1ns/10ps
module slc_wake_filter
  import slc_pkg::*;
(
  input wire slc_mode_t mode_i,
  input wire logic irq_any_i,
  input wire logic pin_irq_i,
  input wire logic twi_match_i,
  input wire logic timer_type_b_irq_i,
  input wire logic periodic_interval_timer_irq_i,
  input wire logic usart_sof_irq_i,
  input wire logic touch_controller_win_irq_i,
  input wire logic rtc_irq_i,
  input wire logic usart_run_in_standby_i,
  input wire logic touch_controller_run_in_standby_i,
  input wire logic rtc_run_in_standby_i,
  output logic wake_o
);

  always_comb
  begin
    wake_o = 1'b0;
    unique case (mode_i)
      SLC_MODE_IDLE, SLC_MODE_RSVD:
        wake_o = irq_any_i;
      SLC_MODE_STANDBY:
        wake_o = pin_irq_i | twi_match_i | timer_type_b_irq_i | periodic_interval_timer_irq_i
                 | (usart_sof_irq_i & usart_run_in_standby_i)
                 | (touch_controller_win_irq_i & touch_controller_run_in_standby_i)
                 | (rtc_irq_i & rtc_run_in_standby_i);
      SLC_MODE_POWER_DOWN:
        wake_o = pin_irq_i | twi_match_i | periodic_interval_timer_irq_i;
    endcase
  end

endmodule : slc_wake_filter

/* File: slc_wake_counter.sv */
// Purpose: counts peripheral clock cycles of the wake-up settle phase
// Assumes: run_i stays high for the whole settle phase
// Notes: done_o rises once CYCLES cycles of run_i have passed and holds until run_i drops
`timescale 1ns/10ps
module slc_wake_counter
#(
  parameter int CYCLES = 6
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic done;
  } slc_cnt_st_t;

  slc_cnt_st_t s_q;
  slc_cnt_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!run_i)
    begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end
    else if (!s_q.done)
    begin
      s_d.cnt = s_q.cnt + CW'(1);
      s_d.done = (s_q.cnt == LAST);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;

endmodule : slc_wake_counter

/* File: slc_sleep_controller.sv */
// Purpose: sleep controller moving the device between Active and three sleep modes
// Assumes: Avalon-MM slave, one clock, interrupt inputs pre-gated by their enables
// Notes: clock and oscillator enables are registered; resume_o pulses on return
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module slc_sleep_controller
  import slc_pkg::*;
#(
  parameter int WAKE_CYCLES = SLC_WAKE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // processor core
  input wire logic sleep_instr_i,
  input wire logic debug_break_i,
  output logic resume_o,
  output logic sleeping_o,
  // wake sources
  input wire logic irq_any_i,
  input wire logic pin_irq_i,
  input wire logic twi_match_i,
  input wire logic timer_type_b_irq_i,
  input wire logic periodic_interval_timer_irq_i,
  input wire logic usart_sof_irq_i,
  input wire logic touch_controller_win_irq_i,
  input wire logic rtc_irq_i,
  // peripheral configuration
  input wire logic usart_run_in_standby_i,
  input wire logic touch_controller_run_in_standby_i,
  input wire logic rtc_run_in_standby_i,
  input wire logic main_osc_run_in_standby_i,
  input wire logic rtc_osc_run_in_standby_i,
  input wire logic brownout_detector_uses_ulp_i,
  input wire logic watchdog_uses_ulp_i,
  input wire logic [1:0] brownout_detector_active_fuse_i,
  input wire logic brownout_detector_ready_i,
  input wire logic main_osc_ready_i,
  // clock domain and oscillator enables
  output logic cpu_clk_en_o,
  output logic peripheral_clock_en_o,
  output logic rtc_clk_en_o,
  output logic touch_controller_clk_en_o,
  output logic main_osc_en_o,
  output logic rtc_osc_en_o,
  output logic ulp_osc_en_o,
  output logic watchdog_clock_en_o,
  output logic periodic_interval_timer_clk_en_o
);

  typedef struct packed
  {
    slc_state_t st;
    slc_mode_t mode;
    logic [SLC_CTRL_W-1:0] ctrl;
    logic [31:0] rdata;
    logic waitreq;
    logic resume;
    slc_gates_t gates;
  } slc_main_st_t;

  slc_main_st_t s_q;
  slc_main_st_t s_d;

  logic wake_req;
  logic settle_done;
  logic bus_req;
  logic bus_ack;

  // reserved codes fall back to Idle so that any interrupt still wakes
  function automatic slc_mode_t slc_eff_mode(input logic [1:0] raw);
    slc_mode_t m;
    m = slc_mode_t'(raw);
    if (m == SLC_MODE_RSVD)
    begin
      m = SLC_MODE_IDLE;
    end
    return m;
  endfunction : slc_eff_mode

  function automatic slc_gates_t slc_gate_map(input slc_state_t st, input slc_mode_t mode);
    slc_gates_t g;
    g = SLC_GATES_RST;
    if (st != SLC_ST_ACTIVE)
    begin
      g.cpu = 1'b0;
      unique case (mode)
        SLC_MODE_IDLE, SLC_MODE_RSVD:
          g.cpu = 1'b0;
        SLC_MODE_STANDBY:
        begin
          g.per = 1'b0;
          g.rtc = rtc_run_in_standby_i;
          g.touch = touch_controller_run_in_standby_i;
          g.main_osc = main_osc_run_in_standby_i;
          g.rtc_osc = rtc_osc_run_in_standby_i;
        end
        SLC_MODE_POWER_DOWN:
        begin
          g.per = 1'b0;
          g.touch = 1'b0;
          g.main_osc = 1'b0;
          g.rtc = brownout_detector_uses_ulp_i | watchdog_uses_ulp_i;
          g.rtc_osc = brownout_detector_uses_ulp_i | watchdog_uses_ulp_i;
          g.ulp_osc = brownout_detector_uses_ulp_i | watchdog_uses_ulp_i;
        end
      endcase
      // the wake path restarts the main source, then the peripheral clock
      if (st == SLC_ST_OSC || st == SLC_ST_SETTLE)
      begin
        g.main_osc = 1'b1;
      end
      if (st == SLC_ST_SETTLE)
      begin
        g.per = 1'b1;
      end
    end
    return g;
  endfunction : slc_gate_map

  slc_wake_filter u_filter
  (
    .mode_i(s_q.mode),
    .irq_any_i(irq_any_i),
    .pin_irq_i(pin_irq_i),
    .twi_match_i(twi_match_i),
    .timer_type_b_irq_i(timer_type_b_irq_i),
    .periodic_interval_timer_irq_i(periodic_interval_timer_irq_i),
    .usart_sof_irq_i(usart_sof_irq_i),
    .touch_controller_win_irq_i(touch_controller_win_irq_i),
    .rtc_irq_i(rtc_irq_i),
    .usart_run_in_standby_i(usart_run_in_standby_i),
    .touch_controller_run_in_standby_i(touch_controller_run_in_standby_i),
    .rtc_run_in_standby_i(rtc_run_in_standby_i),
    .wake_o(wake_req)
  );

  slc_wake_counter #(.CYCLES(WAKE_CYCLES)) u_counter
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(s_q.st == SLC_ST_SETTLE),
    .done_o(settle_done)
  );

  // one wait cycle per access keeps read data registered
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_ack = bus_req & ~s_q.waitreq;

  always_comb
  begin
    s_d = s_q;
    s_d.resume = 1'b0;
    s_d.waitreq = ~(bus_req & s_q.waitreq);

    if (bus_req && s_q.waitreq)
    begin
      unique case (avs_address_i)
        SLC_CTRL_OFS:
          s_d.rdata = {29'h0, s_q.ctrl};
        SLC_STAT_OFS:
          s_d.rdata = {28'h0, (s_q.st == SLC_ST_OSC || s_q.st == SLC_ST_SETTLE),
                       (s_q.st != SLC_ST_ACTIVE), s_q.mode};
        default:
          s_d.rdata = 32'h0;
      endcase
    end

    if (bus_ack && avs_write_i && avs_address_i == SLC_CTRL_OFS && avs_byteenable_i[0])
    begin
      s_d.ctrl = avs_writedata_i[SLC_CTRL_W-1:0];
    end

    unique case (s_q.st)
      SLC_ST_ACTIVE:
      begin
        // sleep without the enable bit is a no-op
        if (sleep_instr_i && s_q.ctrl[SLC_EN_BIT])
        begin
          s_d.st = SLC_ST_SLEEP;
          s_d.mode = slc_eff_mode(s_q.ctrl[SLC_MODE_LSB +: 2]);
        end
      end
      SLC_ST_SLEEP:
      begin
        if (debug_break_i)
        begin
          s_d.st = SLC_ST_ACTIVE;
          s_d.resume = 1'b1;
        end
        else if (wake_req)
        begin
          // idle keeps the main source running, so no start-up wait
          s_d.st = (s_q.mode == SLC_MODE_IDLE) ? SLC_ST_SETTLE : SLC_ST_OSC;
        end
      end
      SLC_ST_OSC:
      begin
        if (debug_break_i)
        begin
          s_d.st = SLC_ST_ACTIVE;
          s_d.resume = 1'b1;
        end
        else if (main_osc_ready_i)
        begin
          s_d.st = SLC_ST_SETTLE;
        end
      end
      SLC_ST_SETTLE:
      begin
        if (debug_break_i)
        begin
          s_d.st = SLC_ST_ACTIVE;
          s_d.resume = 1'b1;
        end
        else if (settle_done &&
                 (brownout_detector_active_fuse_i != SLC_BROWNOUT_WAIT_FUSE || brownout_detector_ready_i))
        begin
          s_d.st = SLC_ST_ACTIVE;
          s_d.resume = 1'b1;
        end
      end
    endcase

    s_d.gates = slc_gate_map(s_d.st, s_d.mode);
  end

  // reset returns straight to active with every domain clocked
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q.st <= SLC_ST_ACTIVE;
      s_q.mode <= SLC_MODE_IDLE;
      s_q.ctrl <= SLC_CTRL_RST;
      s_q.rdata <= 32'h0;
      s_q.waitreq <= 1'b1;
      s_q.resume <= 1'b0;
      s_q.gates <= SLC_GATES_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;
  assign resume_o = s_q.resume;
  assign sleeping_o = (s_q.st != SLC_ST_ACTIVE);
  assign cpu_clk_en_o = s_q.gates.cpu;
  assign peripheral_clock_en_o = s_q.gates.per;
  assign rtc_clk_en_o = s_q.gates.rtc;
  assign touch_controller_clk_en_o = s_q.gates.touch;
  assign main_osc_en_o = s_q.gates.main_osc;
  assign rtc_osc_en_o = s_q.gates.rtc_osc;
  assign ulp_osc_en_o = s_q.gates.ulp_osc;
  assign watchdog_clock_en_o = s_q.gates.wdt;
  assign periodic_interval_timer_clk_en_o = s_q.gates.periodic_interval_timer;

  // helper: cycles spent in the settle phase
  logic [7:0] settle_len_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      settle_len_q <= 8'h00;
    end
    else if (s_q.st != SLC_ST_SETTLE)
    begin
      settle_len_q <= 8'h00;
    end
    else if (settle_len_q != 8'hff)
    begin
      settle_len_q <= settle_len_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_SLEEP_NOP: assert property (s_q.st == SLC_ST_ACTIVE && sleep_instr_i && !s_q.ctrl[SLC_EN_BIT]
    |=> !sleeping_o && cpu_clk_en_o)
    else $error("sleep entered with enable bit clear");

  AST_SLEEP_MODE: assert property (s_q.st == SLC_ST_ACTIVE && sleep_instr_i && s_q.ctrl[SLC_EN_BIT]
    |=> sleeping_o && !cpu_clk_en_o && s_q.mode == slc_eff_mode($past(s_q.ctrl[2:1])))
    else $error("sleep entry took wrong mode");

  AST_RSVD_IDLE: assert property (s_q.st == SLC_ST_ACTIVE && sleep_instr_i && s_q.ctrl == 3'h7
    |=> s_q.mode == SLC_MODE_IDLE)
    else $error("reserved mode not treated as idle");

  AST_IDLE_CLOCKS: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_IDLE
    |-> !cpu_clk_en_o && peripheral_clock_en_o && main_osc_en_o)
    else $error("idle clock gating wrong");

  AST_IDLE_WAKE: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_IDLE && irq_any_i && !debug_break_i
    |=> s_q.st == SLC_ST_SETTLE)
    else $error("idle did not wake on interrupt");

  AST_STBY_WAKE: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_STANDBY && timer_type_b_irq_i
    && !debug_break_i |=> s_q.st == SLC_ST_OSC)
    else $error("standby ignored timer interrupt");

  AST_STBY_SOF: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_STANDBY && !debug_break_i
    && !pin_irq_i && !twi_match_i && !timer_type_b_irq_i && !periodic_interval_timer_irq_i && !rtc_irq_i
    && !touch_controller_win_irq_i && usart_sof_irq_i && !usart_run_in_standby_i |=> s_q.st == SLC_ST_SLEEP)
    else $error("standby woke on frame start without run-in-standby");

  AST_STBY_GATE: assert property (s_q.st == SLC_ST_SLEEP && $past(s_q.st) == SLC_ST_SLEEP
    && s_q.mode == SLC_MODE_STANDBY |-> !peripheral_clock_en_o && rtc_clk_en_o == $past(rtc_run_in_standby_i)
    && main_osc_en_o == $past(main_osc_run_in_standby_i))
    else $error("standby clock gating wrong");

  AST_POWER_DOWN_IGNORE: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_POWER_DOWN && !debug_break_i
    && !pin_irq_i && !twi_match_i && !periodic_interval_timer_irq_i |=> s_q.st == SLC_ST_SLEEP)
    else $error("power down woke on a disallowed source");

  AST_POWER_DOWN_CLK: assert property (s_q.st == SLC_ST_SLEEP && s_q.mode == SLC_MODE_POWER_DOWN
    |-> !peripheral_clock_en_o && !main_osc_en_o && watchdog_clock_en_o && periodic_interval_timer_clk_en_o)
    else $error("power down clock gating wrong");

  AST_POWER_DOWN_ULP: assert property (s_q.st == SLC_ST_SLEEP && $past(s_q.st) == SLC_ST_SLEEP
    && s_q.mode == SLC_MODE_POWER_DOWN
    |-> ulp_osc_en_o == $past(brownout_detector_uses_ulp_i | watchdog_uses_ulp_i))
    else $error("power down low-power oscillator wrong");

  AST_WAKE_DELAY: assert property (s_q.st == SLC_ST_SETTLE && s_d.st == SLC_ST_ACTIVE && !debug_break_i
    |-> settle_len_q >= 8'(WAKE_CYCLES))
    else $error("resumed before wake-up delay");

  AST_BROWNOUT_WAIT: assert property (s_q.st == SLC_ST_SETTLE && !debug_break_i && !brownout_detector_ready_i
    && brownout_detector_active_fuse_i == SLC_BROWNOUT_WAIT_FUSE |=> s_q.st == SLC_ST_SETTLE)
    else $error("resumed before brown-out ready");

  AST_CTRL_READ: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == SLC_CTRL_OFS
    |-> avs_readdata_o[31:3] == 29'h0 && avs_readdata_o[2:0] == s_q.ctrl)
    else $error("control read data wrong");

  AST_RESUME: assert property (resume_o |-> cpu_clk_en_o && !sleeping_o && $past(sleeping_o))
    else $error("resume pulse without return to active");

  AST_DEBUG: assert property (sleeping_o && debug_break_i |=> !sleeping_o && resume_o ##1 !resume_o)
    else $error("debug break did not wake");

endmodule : slc_sleep_controller

/* File: slc_core_model.sv */
// Purpose: processor core model that programs the sleep controller and runs sleep instructions
// Assumes: one request at a time; the slave answers by driving waitrequest low
// Notes: outputs change by non-blocking assignment right after a rising edge
`timescale 1ns/10ps
module slc_core_model
(
  input wire logic clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  output logic sleep_instr_o
);
  initial
  begin
    avs_address_o = 4'h0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'h0;
    sleep_instr_o = 1'b0;
  end

  // the request stands untouched until waitrequest is seen low at an edge
  task automatic access(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be,
                        output logic [31:0] rd, output logic ok);
    int n;
    @(posedge clk_i);
    avs_address_o <= adr;
    avs_writedata_o <= wd;
    avs_byteenable_o <= be;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_i !== 1'b0 && n < 50);
    ok = (avs_waitrequest_i === 1'b0);
    rd = avs_readdata_i;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
  endtask : access

  // single-cycle pulse; software has set mode and enable beforehand
  task automatic exec_sleep();
    @(posedge clk_i);
    sleep_instr_o <= 1'b1;
    @(posedge clk_i);
    sleep_instr_o <= 1'b0;
  endtask : exec_sleep
endmodule : slc_core_model

/* File: test_sleep_mode_controller.sv */
// Purpose: self-checking bench for the sleep controller
// Assumes: default wake count of 6; main oscillator ready unless a case holds it off
// Notes: latencies count edges from the wake source rising to resume being seen
`timescale 1ns/10ps
module test_sleep_mode_controller;
  import slc_pkg::*;
  typedef struct packed
  {
    logic [1:0] mode;
    logic [4:0] rsb;
    logic uses;
    logic [7:0] src;
    logic [8:0] gexp;
    logic [8:0] gmask;
    logic [7:0] lat;
  } slc_row_t;
  logic clk_i, reset_n_i, rd_s, wr_s, slp, dbg, uses, bo_rdy, osc_rdy, wreq, resume, sleeping;
  logic [3:0] adr, be;
  logic [31:0] wdat, rdat, rd;
  logic [7:0] src;
  logic [4:0] rsb;
  logic [1:0] fuse;
  wire slc_gates_t gates;
  int fail_count, total_checks, n;
  slc_row_t r;
  // src: any, pin, twi, timer b, periodic, usart, touch, rtc; lat 0 means no wake expected
  slc_row_t rows [16] = '{
    '{2'h0, 5'h00, 1'b1, 8'h80, 9'h0ff, 9'h1ff, 8'd8}, '{2'h3, 5'h00, 1'b1, 8'h80, 9'h0ff, 9'h1ff, 8'd8},
    '{2'h1, 5'h00, 1'b1, 8'h10, 9'h007, 9'h1ff, 8'd9}, '{2'h1, 5'h00, 1'b1, 8'h08, 9'h007, 9'h1ff, 8'd9},
    '{2'h1, 5'h00, 1'b1, 8'h20, 9'h007, 9'h1ff, 8'd9}, '{2'h1, 5'h00, 1'b1, 8'h04, 9'h007, 9'h1ff, 8'd0},
    '{2'h1, 5'h00, 1'b1, 8'h80, 9'h007, 9'h1ff, 8'd0}, '{2'h1, 5'h02, 1'b1, 8'h01, 9'h017, 9'h1ff, 8'd0},
    '{2'h1, 5'h08, 1'b1, 8'h02, 9'h027, 9'h1ff, 8'd9}, '{2'h1, 5'h1f, 1'b1, 8'h04, 9'h07f, 9'h1ff, 8'd9},
    '{2'h1, 5'h1f, 1'b1, 8'h01, 9'h07f, 9'h1ff, 8'd9}, '{2'h2, 5'h00, 1'b1, 8'h40, 9'h047, 9'h1f7, 8'd9},
    '{2'h2, 5'h1f, 1'b0, 8'h20, 9'h003, 9'h1f3, 8'd9}, '{2'h2, 5'h00, 1'b1, 8'h08, 9'h047, 9'h1f7, 8'd9},
    '{2'h2, 5'h1f, 1'b1, 8'h10, 9'h047, 9'h1f7, 8'd0}, '{2'h2, 5'h1f, 1'b1, 8'h02, 9'h047, 9'h1f7, 8'd0}};

  slc_sleep_controller dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .sleep_instr_i(slp), .debug_break_i(dbg), .resume_o(resume), .sleeping_o(sleeping),
    .irq_any_i(src[7]), .pin_irq_i(src[6]), .twi_match_i(src[5]), .timer_type_b_irq_i(src[4]),
    .periodic_interval_timer_irq_i(src[3]), .usart_sof_irq_i(src[2]), .touch_controller_win_irq_i(src[1]),
    .rtc_irq_i(src[0]), .usart_run_in_standby_i(rsb[4]), .touch_controller_run_in_standby_i(rsb[3]),
    .rtc_run_in_standby_i(rsb[2]), .main_osc_run_in_standby_i(rsb[1]), .rtc_osc_run_in_standby_i(rsb[0]),
    .brownout_detector_uses_ulp_i(uses), .watchdog_uses_ulp_i(uses), .brownout_detector_active_fuse_i(fuse),
    .brownout_detector_ready_i(bo_rdy), .main_osc_ready_i(osc_rdy), .cpu_clk_en_o(gates.cpu),
    .peripheral_clock_en_o(gates.per), .rtc_clk_en_o(gates.rtc), .touch_controller_clk_en_o(gates.touch),
    .main_osc_en_o(gates.main_osc), .rtc_osc_en_o(gates.rtc_osc), .ulp_osc_en_o(gates.ulp_osc),
    .watchdog_clock_en_o(gates.wdt), .periodic_interval_timer_clk_en_o(gates.periodic_interval_timer));

  slc_core_model core_u (.clk_i(clk_i), .avs_waitrequest_i(wreq), .avs_readdata_i(rdat), .avs_address_o(adr),
    .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdat), .avs_byteenable_o(be), .sleep_instr_o(slp));

  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    logic ok;
    core_u.access(wr, a, d, b, rd, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      print_verdict();
    end
  endtask : bus

  // returns the edge count at which resume showed, 0 if it never did; ends on an edge
  task automatic wait_resume(input logic must, output int cnt);
    cnt = 0;
    for (int k = 1; k <= 40 && cnt == 0; k++)
    begin
      @(posedge clk_i);
      #1;
      if (resume === 1'b1)
        cnt = k;
    end
    if (must && cnt == 0)
    begin
      fail_count++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask : wait_resume

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    reset_n_i = 1'b0;
    dbg = 1'b0;
    uses = 1'b1;
    bo_rdy = 1'b0;
    osc_rdy = 1'b1;
    src = 8'h0;
    rsb = 5'h0;
    fuse = 2'h0;
    repeat (9) @(posedge clk_i);
    #1;
    chk({resume, sleeping, wreq, gates}, 12'h3ff);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge clk_i);
      rsb <= r.rsb;
      uses <= r.uses;
      bus(1'b1, SLC_CTRL_OFS, {29'h0, r.mode, 1'b1}, 4'h1);
      core_u.exec_sleep();
      repeat (2) @(posedge clk_i);
      #1;
      chk(sleeping, 1'b1);
      chk(gates & r.gmask, r.gexp);
      bus(1'b0, SLC_STAT_OFS, 32'h0, 4'hf);
      chk(rd[2:0], {1'b1, (r.mode == 2'h3) ? 2'h0 : r.mode});
      src <= r.src;
      wait_resume(r.lat != 8'd0, n);
      chk(32'(n), 32'(r.lat));
      src <= 8'h0;
      if (r.lat == 8'd0)
      begin
        dbg <= 1'b1;
        wait_resume(1'b1, n);
        chk(32'(n), 32'h1);
        dbg <= 1'b0;
      end
      #1;
      chk({sleeping, gates}, 10'h1ff);
    end
    bus(1'b0, SLC_CTRL_OFS, 32'h0, 4'hf);
    chk(rd, 32'h5);
    bus(1'b1, SLC_CTRL_OFS, 32'hffffffff, 4'hf);
    bus(1'b1, SLC_CTRL_OFS, 32'h0, 4'h0);
    bus(1'b0, SLC_CTRL_OFS, 32'h0, 4'hf);
    chk(rd, 32'h7);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b1, SLC_CTRL_OFS, 32'h4, 4'h1);
    core_u.exec_sleep();
    repeat (2) @(posedge clk_i);
    #1;
    chk({sleeping, gates}, 10'h1ff);
    // standby with the main oscillator slow to start
    bus(1'b1, SLC_CTRL_OFS, 32'h3, 4'h1);
    core_u.exec_sleep();
    osc_rdy <= 1'b0;
    src <= 8'h40;
    repeat (11) @(posedge clk_i);
    #1;
    chk({sleeping, gates.main_osc}, 2'h3);
    bus(1'b0, SLC_STAT_OFS, 32'h0, 4'hf);
    chk(rd, 32'hd);
    @(posedge clk_i);
    osc_rdy <= 1'b1;
    wait_resume(1'b1, n);
    chk(32'(n), 32'h8);
    src <= 8'h0;
    fuse <= SLC_BROWNOUT_WAIT_FUSE;
    bus(1'b1, SLC_CTRL_OFS, 32'h1, 4'h1);
    core_u.exec_sleep();
    src <= 8'h80;
    repeat (19) @(posedge clk_i);
    #1;
    chk(sleeping, 1'b1);
    @(posedge clk_i);
    bo_rdy <= 1'b1;
    wait_resume(1'b1, n);
    chk(32'(n), 32'h1);
    src <= 8'h0;
    fuse <= 2'h0;
    bus(1'b1, SLC_CTRL_OFS, 32'h5, 4'h1);
    core_u.exec_sleep();
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b0;
    #1;
    chk({sleeping, gates}, 10'h1ff);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, SLC_CTRL_OFS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule : test_sleep_mode_controller
